// *** shared/sac_pkg.sv ***
// Shared constants for the converter conversion and power control block.
// Assumes a single 40 MHz system clock and an APB register port.
package sac_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CONV_TIME_NS = 1000;
  localparam int unsigned CNT_W        = 16;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] OFF_IRQ_MK = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_COUNT  = 8'h14;

  // Field layout of the control register.
  localparam int unsigned SPAN_W       = 3;
  localparam int unsigned CH0_SPAN_LSB = 0;
  localparam int unsigned CH1_SPAN_LSB = 3;
  localparam logic [2:0]  SPAN_OFF     = 3'h0;
  localparam logic [2:0]  SPAN_RST     = 3'h7;

  // Status register bits.
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_DOWN  = 1;
  localparam int unsigned ST_LVDS  = 2;
  localparam int unsigned ST_ARMED = 3;

  // Interrupt bits.
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_IGNORED = 1;
  localparam int unsigned IRQ_DOWN    = 2;

  localparam int unsigned CODE_W = 16;

  typedef enum logic [1:0] {S_IDLE, S_CONV, S_DOWN} sac_state_t;

  // Least time in ns to whole clock cycles, rounded up, never below one.
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

endpackage

// *** core/sac_edge.sv ***
// Rising edge detector for a pin taken as synchronous to the clock.
// Assumes the caller supplies the internal reset and a clear pulse.
`timescale 1ns/1ps
`default_nettype none
module sac_edge (
  input  wire logic clk_in,   // System clock.
  input  wire logic rst_n_in, // Internal active low reset.
  input  wire logic clr_in,   // Synchronous clear.
  input  wire logic lvl_in,   // Level to watch.
  output logic      rise_out  // One-cycle pulse on a rising edge.
);

  logic prev_q;
  logic prev_d;

  // Previous level; a clear makes a level already high count as new.
  always_comb begin
    prev_d = clr_in ? 1'b0 : lvl_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_out = lvl_in & ~prev_q & ~clr_in;

endmodule // sac_edge
`default_nettype wire

// *** core/sac_ctrl.sv ***
// Conversion and power control of a two-channel simultaneous-sampling converter.
// Assumes pins synchronous to SYS_CLK_IN and an APB master on the register port.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl #(
  parameter int unsigned CONV_TIME_NS = sac_pkg::CONV_TIME_NS
) (
  input  wire logic        SYS_CLK_IN,       // System clock, 40 MHz.
  input  wire logic        RST_N_IN,         // Asynchronous reset, active low.
  input  wire logic        CONV_TRIGGER_IN,  // Conversion trigger pin.
  input  wire logic        POWER_DOWN_IN,    // Power-down input pin.
  input  wire logic        IO_LVDS_SEL_IN,   // Strap: high LVDS, low CMOS.
  input  wire logic [15:0] CH0_CODE_IN,      // Channel 0 code from the core.
  input  wire logic [15:0] CH1_CODE_IN,      // Channel 1 code from the core.
  input  wire logic        PSEL,             // APB select.
  input  wire logic        PENABLE,          // APB enable.
  input  wire logic        PWRITE,           // APB direction.
  input  wire logic [7:0]  PADDR,            // APB byte address.
  input  wire logic [31:0] PWDATA,           // APB write data.
  output logic      [31:0] PRDATA,           // APB read data.
  output logic             PREADY,           // APB ready.
  output logic             PSLVERR,          // APB error on unmapped address.
  output logic             BUSY_OUT,         // Conversion in progress.
  output logic             HOLD_OUT,         // Both sample-and-holds in hold.
  output logic      [2:0]  CH0_SPAN_OUT,     // Channel 0 span in use.
  output logic      [2:0]  CH1_SPAN_OUT,     // Channel 1 span in use.
  output logic             POWERED_DOWN_OUT, // Device powered down.
  output logic             IO_LVDS_OUT,      // Serial standard select.
  output logic             GLOBAL_RESET_OUT, // Pulse on a global reset.
  output logic             IRQ_OUT           // Level interrupt.
);

  localparam int unsigned CONV_CYC = sac_pkg::ns_to_cycles(CONV_TIME_NS);
  localparam logic [sac_pkg::CNT_W-1:0] CONV_LAST = sac_pkg::CNT_W'(CONV_CYC - 1);
  localparam int unsigned W = sac_pkg::SPAN_W;
  localparam int unsigned CW = sac_pkg::CODE_W;

  // Reset release through two flip-flops.
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Edge detection on the trigger and power-down pins.
  logic glob_q;
  logic trig_rise;
  logic pd_rise;

  sac_edge u_trig_edge (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (rst_n),
    .clr_in   (1'b0),
    .lvl_in   (CONV_TRIGGER_IN),
    .rise_out (trig_rise)
  );

  sac_edge u_pd_edge (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (rst_n),
    .clr_in   (glob_q),
    .lvl_in   (POWER_DOWN_IN),
    .rise_out (pd_rise)
  );

  // Control state.
  sac_pkg::sac_state_t      st_q, st_d;
  logic [sac_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [W-1:0]              span0_q, span0_d, span1_q, span1_d;
  logic [W-1:0]              use0_q, use0_d, use1_q, use1_d;
  logic [CW-1:0]             res0_q, res0_d, res1_q, res1_d;
  logic [31:0]               count_q, count_d;
  logic                      armed_q, armed_d;
  logic                      glob_d;
  logic                      lvds_q, lvds_d;
  logic                      strap_q, strap_d;
  logic [sac_pkg::IRQ_W-1:0] ist_q, ist_d, imk_q, imk_d, ev;
  logic [31:0]               rdata_q, rdata_d;
  logic                      rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
  logic                      acc, wr, hit;

  // Helper: the code reported for a channel, all zeros when disabled.
  function automatic logic [CW-1:0] chan_code(input logic [W-1:0] span,
                                              input logic [CW-1:0] code);
    return (span == sac_pkg::SPAN_OFF) ? '0 : code;
  endfunction

  // Helper: whether an address maps to a register.
  function automatic logic mapped(input logic [7:0] a);
    return (a == sac_pkg::OFF_CTRL) || (a == sac_pkg::OFF_STATUS) ||
           (a == sac_pkg::OFF_IRQ_ST) || (a == sac_pkg::OFF_IRQ_MK) ||
           (a == sac_pkg::OFF_RESULT) || (a == sac_pkg::OFF_COUNT);
  endfunction

  assign acc = PSEL & PENABLE & rdy_q;
  assign wr  = acc & PWRITE;
  assign hit = mapped(PADDR);

  // Conversion sequencer and power-down control. The trigger path never looks
  // at serial chip select, so a conversion can start mid serial transfer.
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    use0_d  = use0_q;
    use1_d  = use1_q;
    res0_d  = res0_q;
    res1_d  = res1_q;
    count_d = count_q;
    armed_d = armed_q;
    glob_d  = 1'b0;
    ev      = '0;
    unique case (st_q)
      sac_pkg::S_IDLE: begin
        if (POWER_DOWN_IN) begin
          st_d = sac_pkg::S_DOWN;
          ev[sac_pkg::IRQ_DOWN] = 1'b1;
          if (trig_rise) begin
            ev[sac_pkg::IRQ_IGNORED] = 1'b1;
          end
        end else if (trig_rise) begin
          st_d    = sac_pkg::S_CONV;
          cnt_d   = CONV_LAST;
          use0_d  = span0_q;
          use1_d  = span1_q;
          armed_d = 1'b0;
        end
      end
      sac_pkg::S_CONV: begin
        if (trig_rise) begin
          ev[sac_pkg::IRQ_IGNORED] = 1'b1;
        end
        if (cnt_q == '0) begin
          // Both codes are latched on the same edge from one sample instant.
          res0_d  = chan_code(use0_q, CH0_CODE_IN);
          res1_d  = chan_code(use1_q, CH1_CODE_IN);
          count_d = count_q + 32'h00000001;
          ev[sac_pkg::IRQ_DONE] = 1'b1;
          if (POWER_DOWN_IN) begin
            st_d = sac_pkg::S_DOWN;
            ev[sac_pkg::IRQ_DOWN] = 1'b1;
          end else begin
            st_d = sac_pkg::S_IDLE;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      sac_pkg::S_DOWN: begin
        if (trig_rise) begin
          ev[sac_pkg::IRQ_IGNORED] = 1'b1;
        end
        if (!POWER_DOWN_IN) begin
          st_d = sac_pkg::S_IDLE;
        end
      end
    endcase
    // A raise while already armed is the second one with no conversion between.
    if (pd_rise) begin
      if (armed_q && !(st_q == sac_pkg::S_IDLE && trig_rise && !POWER_DOWN_IN)) begin
        glob_d = 1'b1;
      end else begin
        armed_d = 1'b1;
      end
    end
    // Global reset returns all sequencer state here to its power-on value.
    if (glob_q) begin
      st_d    = sac_pkg::S_IDLE;
      cnt_d   = '0;
      use0_d  = sac_pkg::SPAN_RST;
      use1_d  = sac_pkg::SPAN_RST;
      res0_d  = '0;
      res1_d  = '0;
      count_d = '0;
      armed_d = 1'b0;
      glob_d  = 1'b0;
      ev      = '0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= sac_pkg::S_IDLE;
      cnt_q   <= '0;
      use0_q  <= sac_pkg::SPAN_RST;
      use1_q  <= sac_pkg::SPAN_RST;
      res0_q  <= '0;
      res1_q  <= '0;
      count_q <= '0;
      armed_q <= 1'b0;
      glob_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      use0_q  <= use0_d;
      use1_q  <= use1_d;
      res0_q  <= res0_d;
      res1_q  <= res1_d;
      count_q <= count_d;
      armed_q <= armed_d;
      glob_q  <= glob_d;
    end
  end

  // Strap capture in the first cycle after reset release and again after a global
  // reset; any other later change of the pin is not followed, since the board fixes it.
  always_comb begin
    strap_d = 1'b1;
    lvds_d  = strap_q ? lvds_q : IO_LVDS_SEL_IN;
    if (glob_q) begin
      strap_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= 1'b0;
      lvds_q  <= 1'b0;
    end else begin
      strap_q <= strap_d;
      lvds_q  <= lvds_d;
    end
  end

  // APB slave: ready is raised for the access phase, so every transfer has
  // no wait state; writes and sticky-bit clears act at that edge.
  always_comb begin
    span0_d = span0_q;
    span1_d = span1_q;
    imk_d   = imk_q;
    rdata_d = rdata_q;
    err_d   = 1'b0;
    rdy_d   = PSEL & ~PENABLE;
    // A new event wins over a write-one clear in the same cycle.
    ist_d   = (ist_q & ~((wr && PADDR == sac_pkg::OFF_IRQ_ST) ?
                         PWDATA[sac_pkg::IRQ_W-1:0] : '0)) | ev;
    if (PSEL && !PENABLE) begin
      err_d   = ~mapped(PADDR);
      rdata_d = '0;
      if (!PWRITE) begin
        unique case (PADDR)
          sac_pkg::OFF_CTRL: begin
            rdata_d[sac_pkg::CH0_SPAN_LSB +: W] = span0_q;
            rdata_d[sac_pkg::CH1_SPAN_LSB +: W] = span1_q;
          end
          sac_pkg::OFF_STATUS: begin
            rdata_d[sac_pkg::ST_BUSY]  = BUSY_OUT;
            rdata_d[sac_pkg::ST_DOWN]  = POWERED_DOWN_OUT;
            rdata_d[sac_pkg::ST_LVDS]  = lvds_q;
            rdata_d[sac_pkg::ST_ARMED] = armed_q;
          end
          sac_pkg::OFF_IRQ_ST: rdata_d[sac_pkg::IRQ_W-1:0] = ist_q;
          sac_pkg::OFF_IRQ_MK: rdata_d[sac_pkg::IRQ_W-1:0] = imk_q;
          sac_pkg::OFF_RESULT: rdata_d = {res1_q, res0_q};
          sac_pkg::OFF_COUNT:  rdata_d = count_q;
          default:             rdata_d = '0;
        endcase
      end
    end
    if (wr && hit) begin
      if (PADDR == sac_pkg::OFF_CTRL) begin
        span0_d = PWDATA[sac_pkg::CH0_SPAN_LSB +: W];
        span1_d = PWDATA[sac_pkg::CH1_SPAN_LSB +: W];
      end
      if (PADDR == sac_pkg::OFF_IRQ_MK) begin
        imk_d = PWDATA[sac_pkg::IRQ_W-1:0];
      end
    end
    if (glob_q) begin
      span0_d = sac_pkg::SPAN_RST;
      span1_d = sac_pkg::SPAN_RST;
      imk_d   = '0;
      ist_d   = '0;
    end
    irq_d = |(ist_d & imk_d);
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      span0_q <= sac_pkg::SPAN_RST;
      span1_q <= sac_pkg::SPAN_RST;
      imk_q   <= '0;
      ist_q   <= '0;
      rdata_q <= '0;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      span0_q <= span0_d;
      span1_q <= span1_d;
      imk_q   <= imk_d;
      ist_q   <= ist_d;
      rdata_q <= rdata_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      irq_q   <= irq_d;
    end
  end

  // Pin-facing outputs, all registered. Busy and hold are decoded from the next
  // state, so they change on the same edge as the sequencer state: the edge after the trigger pin rises.
  logic busy_q, pdn_q, grst_q;

  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      pdn_q  <= 1'b0;
      grst_q <= 1'b0;
    end else begin
      busy_q <= (st_d == sac_pkg::S_CONV);
      pdn_q  <= (st_d == sac_pkg::S_DOWN);
      grst_q <= glob_d;
    end
  end

  assign BUSY_OUT         = busy_q;
  assign HOLD_OUT         = busy_q;
  assign CH0_SPAN_OUT     = use0_q;
  assign CH1_SPAN_OUT     = use1_q;
  assign POWERED_DOWN_OUT = pdn_q;
  assign IO_LVDS_OUT      = lvds_q;
  assign GLOBAL_RESET_OUT = grst_q;
  assign IRQ_OUT          = irq_q;
  assign PRDATA           = rdata_q;
  assign PREADY           = rdy_q;
  assign PSLVERR          = err_q; // Set only by a setup cycle, so it stands with ready.

endmodule // sac_ctrl
`default_nettype wire

// *** verif/sac_ctrl_props.sv ***
// Concurrent checks on the ports of the conversion and power control block.
// Assumes one clock domain and is bound onto every instance of sac_ctrl.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_props #(
  parameter int unsigned CONV_TIME_NS = sac_pkg::CONV_TIME_NS
) (
  input wire logic       SYS_CLK_IN,       // Clock.
  input wire logic       RST_N_IN,         // Reset, active low.
  input wire logic       CONV_TRIGGER_IN,  // Trigger pin.
  input wire logic       POWER_DOWN_IN,    // Power-down pin.
  input wire logic       PSEL,             // APB select.
  input wire logic       PENABLE,          // APB enable.
  input wire logic       PREADY,           // APB ready.
  input wire logic       BUSY_OUT,         // Busy.
  input wire logic       HOLD_OUT,         // Hold.
  input wire logic [2:0] CH0_SPAN_OUT,     // Span 0.
  input wire logic [2:0] CH1_SPAN_OUT,     // Span 1.
  input wire logic       POWERED_DOWN_OUT, // Down.
  input wire logic       GLOBAL_RESET_OUT  // Global reset pulse.
);
  localparam int N = (CONV_TIME_NS * (sac_pkg::CLK_HZ / 1000000) + 999) / 1000;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // Length of the current busy run, so a run of any length can be judged.
  always_comb cnt_d = BUSY_OUT ? cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) cnt_q <= 16'h0000;
    else cnt_q <= cnt_d;
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_trig_starts_busy:
  assert property ($rose(CONV_TRIGGER_IN) && !BUSY_OUT && !POWERED_DOWN_OUT && !POWER_DOWN_IN
    && !GLOBAL_RESET_OUT |=> BUSY_OUT) else $error("trigger edge started no conversion");
  a_hold_is_busy:
  assert property (HOLD_OUT == BUSY_OUT) else $error("hold differs from busy");
  a_busy_run_length:
  assert property ($fell(BUSY_OUT) |-> cnt_q == 16'(N)) else $error("busy run length wrong");
  a_pd_no_start:
  assert property (POWER_DOWN_IN |=> !$rose(BUSY_OUT)) else $error("start taken in power-down");
  a_pd_enters_down:
  assert property (POWER_DOWN_IN && !BUSY_OUT && !GLOBAL_RESET_OUT && !$past(GLOBAL_RESET_OUT)
    && !$past(GLOBAL_RESET_OUT, 2) |=> POWERED_DOWN_OUT) else $error("power-down not entered");
  a_pd_leaves_down:
  assert property (!POWER_DOWN_IN && POWERED_DOWN_OUT |=> !POWERED_DOWN_OUT)
    else $error("power-down not left");
  a_conv_before_down:
  assert property (BUSY_OUT |-> !POWERED_DOWN_OUT) else $error("down during a conversion");
  // State is back to reset values the cycle after the pulse; a trigger one cycle
  // later may legally start a conversion, so only that first cycle is judged.
  a_global_clears:
  assert property (GLOBAL_RESET_OUT |=> !GLOBAL_RESET_OUT && CH0_SPAN_OUT == sac_pkg::SPAN_RST
    && CH1_SPAN_OUT == sac_pkg::SPAN_RST && !BUSY_OUT) else $error("global reset left state");
  a_apb_zero_wait:
  assert property (PSEL && !PENABLE |=> PREADY) else $error("ready not in access cycle");
  a_ready_in_access:
  assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");

  // The main scenarios should all be reached by the bench.
  c_conv_done: cover property ($fell(BUSY_OUT));
  c_global_reset: cover property (GLOBAL_RESET_OUT);
  c_pd_in_conv: cover property (POWER_DOWN_IN && BUSY_OUT);
endmodule // sac_ctrl_props

bind sac_ctrl sac_ctrl_props #(.CONV_TIME_NS(CONV_TIME_NS)) u_props (
  .SYS_CLK_IN, .RST_N_IN, .CONV_TRIGGER_IN, .POWER_DOWN_IN, .PSEL, .PENABLE, .PREADY,
  .BUSY_OUT, .HOLD_OUT, .CH0_SPAN_OUT, .CH1_SPAN_OUT, .POWERED_DOWN_OUT, .GLOBAL_RESET_OUT
);
`default_nettype wire

// *** verif/sac_host_model.sv ***
// Host side of the converter: trigger and power-down pins, strap and core codes.
// Assumes requests from the bench, applied one clock edge later.
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  input  wire logic        clk_in,      // Clock.
  input  wire logic        strap_in,    // Board strap level.
  input  wire logic        conv_req_in, // Trigger request level.
  input  wire logic        pd_req_in,   // Power-down request level.
  input  wire logic [15:0] c0_in,       // Next channel 0 code.
  input  wire logic [15:0] c1_in,       // Next channel 1 code.
  output logic             trig_out,    // Trigger pin.
  output logic             pd_out,      // Power-down pin.
  output logic             strap_out,   // Serial standard strap.
  output logic      [15:0] ch0_out,     // Channel 0 code.
  output logic      [15:0] ch1_out      // Channel 1 code.
);
  logic        trig_q = 1'b0;
  logic        pd_q = 1'b0;
  logic [15:0] c0_q = 16'h0000;
  logic [15:0] c1_q = 16'h0000;

  // Pins move just after an edge, as a clocked host would drive them.
  always @(posedge clk_in) begin
    trig_q <= conv_req_in;
    pd_q <= pd_req_in;
    c0_q <= c0_in;
    c1_q <= c1_in;
  end

  // The strap is a board level; the bench moves it only while reset is held.
  assign strap_out = strap_in;
  assign trig_out = trig_q;
  assign pd_out = pd_q;
  assign ch0_out = c0_q;
  assign ch1_out = c1_q;
endmodule // sac_host_model
`default_nettype wire

// *** verif/sac_ctrl_tb_top.sv ***
// Self-checking bench for the conversion and power control block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_tb_top;
  localparam int unsigned CT = 100;
  localparam int N = (CT * (sac_pkg::CLK_HZ / 1000000) + 999) / 1000;
  logic        SYS_CLK_IN = 1'b0, RST_N_IN = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, BUSY_OUT, HOLD_OUT, POWERED_DOWN_OUT, IO_LVDS_OUT;
  logic        GLOBAL_RESET_OUT, IRQ_OUT, CONV_TRIGGER_IN, POWER_DOWN_IN, IO_LVDS_SEL_IN;
  logic [15:0] CH0_CODE_IN, CH1_CODE_IN, c0 = 16'h0, c1 = 16'h0, rnd = 16'h0030;
  logic [2:0]  CH0_SPAN_OUT, CH1_SPAN_OUT, s0, s1;
  logic        req = 1'b0, pdr = 1'b0, gr_seen = 1'b0, er, strap = 1'b1;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, nb;

  sac_ctrl #(.CONV_TIME_NS(CT)) dut (.SYS_CLK_IN, .RST_N_IN, .CONV_TRIGGER_IN, .POWER_DOWN_IN,
    .IO_LVDS_SEL_IN, .CH0_CODE_IN, .CH1_CODE_IN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .BUSY_OUT, .HOLD_OUT, .CH0_SPAN_OUT, .CH1_SPAN_OUT,
    .POWERED_DOWN_OUT, .IO_LVDS_OUT, .GLOBAL_RESET_OUT, .IRQ_OUT);
  sac_host_model u_host (.clk_in(SYS_CLK_IN), .strap_in(strap), .conv_req_in(req),
    .pd_req_in(pdr), .c0_in(c0),
    .c1_in(c1), .trig_out(CONV_TRIGGER_IN), .pd_out(POWER_DOWN_IN), .strap_out(IO_LVDS_SEL_IN),
    .ch0_out(CH0_CODE_IN), .ch1_out(CH1_CODE_IN));

  // Clock at 40 MHz.
  always #12.5 SYS_CLK_IN = ~SYS_CLK_IN;

  // Hang guard, and a latch of any global reset pulse, which lasts one cycle only.
  always @(posedge SYS_CLK_IN) begin
    cyc <= cyc + 1;
    if (GLOBAL_RESET_OUT === 1'b1) gr_seen <= 1'b1;
    if (cyc == 4000) begin
      n_mismatch++;
      close_out;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // A disabled channel reads as zero, an enabled one passes its code.
  function automatic logic [31:0] exp_res(input logic [2:0] a, b, input logic [15:0] x, y);
    return {(b == 3'h0) ? 16'h0000 : y, (a == 3'h0) ? 16'h0000 : x};
  endfunction

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; the leading edge keeps back-to-back calls from clashing.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK_IN);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK_IN) PENABLE <= 1'b1;
    @(posedge SYS_CLK_IN);
    while (PREADY !== 1'b1) @(posedge SYS_CLK_IN);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // One conversion; x=1 adds a trigger while busy, x=2 raises power-down while busy.
  task conv(input int x);
    req <= 1'b1;
    @(posedge SYS_CLK_IN) req <= 1'b0;
    for (int i = 0; i < 10 && BUSY_OUT !== 1'b1; i++) @(posedge SYS_CLK_IN);
    req <= (x == 1);
    if (x == 2) pdr <= 1'b1;
    nb = 0;
    while (BUSY_OUT === 1'b1 && nb < 50) begin
      @(posedge SYS_CLK_IN) req <= 1'b0;
      nb++;
    end
  endtask

  task pd(input logic v);
    pdr <= v;
    repeat (4) @(posedge SYS_CLK_IN);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: reset values, random conversions, then power-down and global reset.
  initial begin
    repeat (2) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (4) @(posedge SYS_CLK_IN);
    apb(1'b0, 8'h00, 32'h0); chk("ctrl reset", 32'h3F, rd);
    apb(1'b0, 8'h04, 32'h0); chk("status reset", 32'h4, rd);
    chk("lvds select", 32'h1, IO_LVDS_OUT);
    apb(1'b0, 8'h0C, 32'h0); chk("mask reset", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0); chk("unmapped error", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h0C, 32'h1);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      s0 = (k == 0) ? 3'h0 : rnd[2:0];
      s1 = rnd[5:3];
      c0 <= rnd;
      rnd = lfsr(rnd);
      c1 <= rnd;
      apb(1'b1, 8'h00, {26'h0, s1, s0});
      conv(k % 2);
      chk("busy cycles", N, nb);
      chk("spans", {s1, s0}, {CH1_SPAN_OUT, CH0_SPAN_OUT});
      apb(1'b0, 8'h10, 32'h0); chk("result", exp_res(s0, s1, c0, c1), rd);
      apb(1'b0, 8'h14, 32'h0); chk("count", k + 1, rd);
      apb(1'b0, 8'h08, 32'h0); chk("irq status", {30'h0, k[0], 1'b1}, rd);
      chk("irq on", 32'h1, IRQ_OUT);
      apb(1'b1, 8'h08, 32'h7);
      apb(1'b0, 8'h08, 32'h0); chk("irq cleared", 32'h0, rd);
      chk("irq off", 32'h0, IRQ_OUT);
    end
    $display("test convert done");
    apb(1'b1, 8'h0C, 32'h4);
    conv(2); chk("busy with pd", N, nb);
    repeat (2) @(posedge SYS_CLK_IN);
    chk("down after conv", 32'h1, POWERED_DOWN_OUT);
    req <= 1'b1;
    @(posedge SYS_CLK_IN) req <= 1'b0;
    repeat (4) @(posedge SYS_CLK_IN);
    chk("no conv while down", 32'h0, BUSY_OUT);
    apb(1'b0, 8'h08, 32'h0); chk("irq status down", 32'h7, rd);
    chk("irq down", 32'h1, IRQ_OUT);
    apb(1'b0, 8'h04, 32'h0); chk("status down", 32'hE, rd);
    pd(1'b0); chk("up again", 32'h0, POWERED_DOWN_OUT);
    conv(0);
    pd(1'b1);
    pd(1'b0); chk("no global reset", 32'h0, gr_seen);
    apb(1'b1, 8'h00, 32'h12);
    pd(1'b1); chk("global reset", 32'h1, gr_seen);
    pd(1'b0);
    apb(1'b0, 8'h00, 32'h0); chk("ctrl after reset", 32'h3F, rd);
    apb(1'b0, 8'h14, 32'h0); chk("count after reset", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0); chk("mask after reset", 32'h0, rd);
    $display("test power done");
    // Second reset in mid-run with the strap moved to the single-ended standard.
    strap <= 1'b0;
    RST_N_IN <= 1'b0;
    repeat (2) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (4) @(posedge SYS_CLK_IN);
    chk("cmos select", 32'h0, IO_LVDS_OUT);
    chk("spans after rst", 32'h3F, {CH1_SPAN_OUT, CH0_SPAN_OUT});
    apb(1'b0, 8'h04, 32'h0); chk("status cmos", 32'h0, rd);
    conv(0); chk("busy after rst", N, nb);
    $display("test second reset done");
    close_out;
  end
endmodule // sac_ctrl_tb_top
`default_nettype wire
